// ### core/cap_pkg.sv
/*
  Package for the cache allocation and write policy block: attribute width,
  bit positions and states.
  Assumes a single clock domain; no registers reachable by software.
*/
`default_nettype none
package cap_pkg;
  // Attribute field positions, ordered write-alloc, read-alloc, cacheable, bufferable
  localparam int CAP_ATTR_W = 4;
  localparam int CAP_BIT_WA = 3;
  localparam int CAP_BIT_RA = 2;
  localparam int CAP_BIT_C = 1;
  localparam int CAP_BIT_B = 0;
  // Decision state
  typedef enum logic [1:0] {
    CAP_IDLE,
    CAP_FILL,
    CAP_DONE
  } cap_state_t;
endpackage : cap_pkg
`default_nettype wire

// ### core/cap_attr_dec.sv
/*
  Attribute decoder: splits the 4-bit cache attribute into policy classes.
  Assumes the attribute is already registered on the block clock.
*/
`default_nettype none
module cap_attr_dec
  import cap_pkg::*;
(
  input wire logic [CAP_ATTR_W-1:0] attr,
  output logic cacheable,
  output logic read_alloc,
  output logic write_alloc,
  output logic write_back
);
  // Cacheable with neither allocate bit still counts as outer non-cacheable
  assign cacheable = attr[CAP_BIT_C] & (attr[CAP_BIT_WA] | attr[CAP_BIT_RA]);
  assign read_alloc = cacheable & attr[CAP_BIT_RA];
  assign write_alloc = cacheable & attr[CAP_BIT_WA];
  assign write_back = cacheable & attr[CAP_BIT_B];
endmodule : cap_attr_dec
`default_nettype wire

// ### core/cap_policy.sv
/*
  Cache allocation and write policy. Lookups arrive as a request carrying the
  attribute, direction and hit result; store-buffer drains arrive as a second
  request carrying the attribute and hit result plus a "fully populated" flag.
  The block answers with one-cycle action strobes and data-path steering.
  Assumes a single clock; all requesters are logic on that clock.
*/
`default_nettype none
module cap_policy
  import cap_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  // Lookup request from the slave side
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [CAP_ATTR_W-1:0] req_attr,
  input wire logic req_hit,
  output logic req_ready,
  // Lookup decision, registered, one-cycle pulses
  output logic rd_from_cache,
  output logic rd_from_next,
  output logic rd_linefill,
  output logic wr_to_buffer,
  // Store-buffer drain request
  input wire logic drn_valid,
  input wire logic [CAP_ATTR_W-1:0] drn_attr,
  input wire logic drn_hit,
  input wire logic drn_full,
  output logic drn_ready,
  // Fetch of missing data from next level
  output logic fetch_req,
  input wire logic fetch_done,
  // Drain actions, registered, one-cycle pulses
  output logic drn_done,
  output logic wr_cache,
  output logic wr_next,
  output logic alloc_line,
  output logic set_dirty
);
  // Lookup-side class decode
  logic lk_c, lk_ra, lk_wa, lk_wb;
  // Drain-side class decode
  logic dr_c, dr_ra, dr_wa, dr_wb;
  cap_attr_dec u_dec_lk (
    .attr(req_attr),
    .cacheable(lk_c),
    .read_alloc(lk_ra),
    .write_alloc(lk_wa),
    .write_back(lk_wb)
  );
  cap_attr_dec u_dec_dr (
    .attr(drn_attr),
    .cacheable(dr_c),
    .read_alloc(dr_ra),
    .write_alloc(dr_wa),
    .write_back(dr_wb)
  );

  // Lookup decisions; the master keeps to the attribute encoding
  wire lk_go = req_valid & req_ready;
  wire lk_rd = lk_go & ~req_write;
  wire hit_rd_next = lk_rd & lk_c & req_hit;
  wire miss_fill_next = lk_rd & lk_c & ~req_hit & lk_ra;
  wire rd_next_next = lk_rd & (~lk_c | (~req_hit & ~lk_ra));
  wire wr_buf_next = lk_go & req_write;

  // Lookup path is always ready: decisions take one cycle
  assign req_ready = 1'b1;

  // Registered lookup strobes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_from_cache <= 1'b0;
      rd_linefill <= 1'b0;
      rd_from_next <= 1'b0;
      wr_to_buffer <= 1'b0;
    end else begin
      rd_from_cache <= hit_rd_next;
      rd_linefill <= miss_fill_next;
      rd_from_next <= rd_next_next;
      wr_to_buffer <= wr_buf_next;
    end
  end

  // Drain state machine: a partial write-allocate miss waits for a fetch
  cap_state_t state_reg, state_next;
  logic alloc_pend_reg, alloc_pend_next; // Write-allocate miss in flight
  logic wt_pend_reg, wt_pend_next; // Its type is write-through
  logic dn_go;
  logic wa_miss;

  assign drn_ready = (state_reg == CAP_IDLE);
  assign dn_go = drn_valid & drn_ready;
  assign wa_miss = dr_wa & ~drn_hit;

  // Next drain actions
  logic wc_n, wn_n, al_n, sd_n, dd_n, fr_n;

  // Next-state and action decode
  always_comb begin
    state_next = state_reg;
    alloc_pend_next = alloc_pend_reg;
    wt_pend_next = wt_pend_reg;
    wc_n = 1'b0;
    wn_n = 1'b0;
    al_n = 1'b0;
    sd_n = 1'b0;
    dd_n = 1'b0;
    fr_n = 1'b0;
    case (state_reg)
      CAP_IDLE: begin
        if (dn_go) begin
          if (!dr_c) begin
            wn_n = 1'b1;
            dd_n = 1'b1;
          end else if (drn_hit) begin
            wc_n = 1'b1;
            wn_n = ~dr_wb;
            sd_n = dr_wb;
            dd_n = 1'b1;
          end else if (!wa_miss) begin
            wn_n = 1'b1;
            dd_n = 1'b1;
          end else if (drn_full) begin
            // Fully covered: allocate straight away
            wc_n = 1'b1;
            al_n = 1'b1;
            wn_n = ~dr_wb;
            sd_n = dr_wb;
            dd_n = 1'b1;
          end else begin
            fr_n = 1'b1;
            alloc_pend_next = 1'b1;
            wt_pend_next = ~dr_wb;
            state_next = CAP_FILL;
          end
        end
      end
      CAP_FILL: begin
        // Merge only once the missing data has arrived
        if (fetch_done) begin
          state_next = CAP_DONE;
        end
      end
      CAP_DONE: begin
        wc_n = 1'b1;
        al_n = 1'b1;
        wn_n = wt_pend_reg;
        sd_n = ~wt_pend_reg;
        dd_n = 1'b1;
        alloc_pend_next = 1'b0;
        state_next = CAP_IDLE;
      end
      default: begin
        state_next = CAP_IDLE;
      end
    endcase
  end

  // State and action registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= CAP_IDLE;
      alloc_pend_reg <= 1'b0;
      wt_pend_reg <= 1'b0;
      wr_cache <= 1'b0;
      wr_next <= 1'b0;
      alloc_line <= 1'b0;
      set_dirty <= 1'b0;
      drn_done <= 1'b0;
      fetch_req <= 1'b0;
    end else begin
      state_reg <= state_next;
      alloc_pend_reg <= alloc_pend_next;
      wt_pend_reg <= wt_pend_next;
      wr_cache <= wc_n;
      wr_next <= wn_n;
      alloc_line <= al_n;
      set_dirty <= sd_n;
      drn_done <= dd_n;
      fetch_req <= fr_n;
    end
  end

  // Assertions
  a_nc_read_fwd: assert property (@(posedge clk) disable iff (!resetn)
    (lk_rd && !lk_c) |=> (rd_from_next && !rd_linefill && !rd_from_cache))
    else $error("non-cacheable read not forwarded");
  a_hit_from_cache: assert property (@(posedge clk) disable iff (!resetn)
    (lk_rd && lk_c && req_hit) |=> (rd_from_cache && !rd_from_next))
    else $error("cacheable read hit not served from cache");
  a_ra_miss_fill: assert property (@(posedge clk) disable iff (!resetn)
    (lk_rd && lk_ra && !req_hit) |=> rd_linefill)
    else $error("read-allocate miss without linefill");
  a_wa_only_read: assert property (@(posedge clk) disable iff (!resetn)
    (lk_rd && lk_c && !lk_ra && !req_hit) |=> (rd_from_next && !rd_linefill))
    else $error("write-allocate-only read miss allocated");
  a_nc_write_next: assert property (@(posedge clk) disable iff (!resetn)
    (dn_go && !dr_c) |=> (wr_next && !wr_cache && !alloc_line))
    else $error("non-cacheable write touched cache");
  a_wt_hit_both: assert property (@(posedge clk) disable iff (!resetn)
    (dn_go && dr_c && drn_hit && !dr_wb) |=> (wr_cache && wr_next && !set_dirty))
    else $error("write-through hit wrong");
  a_wb_hit_dirty: assert property (@(posedge clk) disable iff (!resetn)
    (dn_go && dr_c && drn_hit && dr_wb) |=> (wr_cache && !wr_next && set_dirty))
    else $error("write-back hit wrong");
  a_nwa_miss_next: assert property (@(posedge clk) disable iff (!resetn)
    (dn_go && dr_c && !drn_hit && !dr_wa) |=> (wr_next && !alloc_line && !wr_cache))
    else $error("no-allocate write miss allocated");
  a_part_fetch: assert property (@(posedge clk) disable iff (!resetn)
    (dn_go && dr_c && wa_miss && !drn_full) |=> (fetch_req && !alloc_line && !drn_ready))
    else $error("partial entry allocated before fetch");
  // While the fetch is outstanding nothing may be allocated or reported done
  a_fill_no_alloc: assert property (@(posedge clk) disable iff (!resetn)
    (state_reg == CAP_FILL) |-> (!alloc_line && !drn_done && alloc_pend_reg))
    else $error("allocation during outstanding fetch");
  a_fill_alloc: assert property (@(posedge clk) disable iff (!resetn)
    (state_reg == CAP_FILL && fetch_done) |=> ##1 (alloc_line && wr_cache && drn_done))
    else $error("fill not followed by allocation");
  a_wb_alloc_dirty: assert property (@(posedge clk) disable iff (!resetn)
    (alloc_line && !wr_next) |-> set_dirty)
    else $error("write-back allocated line left clean");
endmodule : cap_policy
`default_nettype wire

// ### verification/cap_next_level.sv
/* Next memory level model: answers each fetch request with a fetch_done pulse.
   Assumes fetch_req is a one-cycle pulse on clk. */
`default_nettype none
module cap_next_level (
  input wire logic clk,
  input wire logic resetn,
  input wire logic fetch_req,
  input wire logic [3:0] dly,
  output var logic fetch_done
);
  timeunit 1ns;
  timeprecision 1ps;
  initial fetch_done = 1'b0;
  // Delay of dly cycles lets a scenario choose a prompt or a slow memory
  always @(posedge clk) begin
    if (fetch_req && resetn) begin
      repeat (dly) @(posedge clk);
      fetch_done <= 1'b1;
      @(posedge clk);
      fetch_done <= 1'b0;
    end
  end
endmodule // cap_next_level
`default_nettype wire

// ### verification/cap_policy_test.sv
/* Self-checking bench for cap_policy: lookups and store-buffer drains.
   Assumes cap_pkg and the next level model are compiled first. */
`default_nettype none
module cap_policy_test
  import cap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0, req_write = 1'b0, req_hit = 1'b0;
  logic drn_valid = 1'b0, drn_hit = 1'b0, drn_full = 1'b0;
  logic [CAP_ATTR_W-1:0] req_attr = 4'h0, drn_attr = 4'h0;
  logic [3:0] dly = 4'h0; // Memory answer delay
  logic req_ready, rd_from_cache, rd_from_next, rd_linefill, wr_to_buffer, drn_ready;
  logic fetch_req, fetch_done, drn_done, wr_cache, wr_next, alloc_line, set_dirty;
  int errors = 0;
  int samples_checked = 0;
  // 250 MHz
  always #2 clk = ~clk;
  cap_policy i_dut (.clk, .resetn, .req_valid, .req_write, .req_attr, .req_hit, .req_ready,
    .rd_from_cache, .rd_from_next, .rd_linefill, .wr_to_buffer, .drn_valid, .drn_attr,
    .drn_hit, .drn_full, .drn_ready, .fetch_req, .fetch_done, .drn_done, .wr_cache,
    .wr_next, .alloc_line, .set_dirty);
  cap_next_level i_mem (.clk, .resetn, .fetch_req, .dly, .fetch_done);
  // Single comparison kind: a vector of strobes
  task automatic chk(input logic [5:0] got, input logic [5:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  task automatic close_out();
    $display("Counts: errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Lookup held for one edge; caller lowers req_valid, so calls run back to back
  task automatic look(input logic w, input logic [3:0] a, input logic h, input logic [3:0] e);
    req_valid = 1'b1;
    req_write = w;
    req_attr = a;
    req_hit = h;
    @(negedge clk);
    chk({2'b00, rd_from_cache, rd_from_next, rd_linefill, wr_to_buffer}, {2'b00, e}, "lookup");
  endtask
  // Drain one entry; e is {cache, next, alloc, dirty, fetched}
  task automatic drain(input logic [3:0] a, input logic h, input logic f, input logic [4:0] e);
    logic fetched;
    int n;
    fetched = 1'b0;
    drn_valid = 1'b1;
    drn_attr = a;
    drn_hit = h;
    drn_full = f;
    @(negedge clk);
    drn_valid = 1'b0;
    // Bounded wait: a lost fetch answer must not hang the run
    for (n = 0; n < 40 && drn_done !== 1'b1; n++) begin
      if (fetch_req === 1'b1) begin
        fetched = 1'b1;
        chk({5'h00, drn_ready}, 6'h00, "ready in fill");
      end
      @(negedge clk);
    end
    chk({wr_cache, wr_next, alloc_line, set_dirty, fetched, drn_ready}, {e, 1'b1}, "drain");
    // Let one edge pass so the next call does not raise drn_valid in the step that lowered it
    @(negedge clk);
    if (n == 40) begin
      errors++;
      close_out();
    end
  endtask
  // Outputs quiet, both ready high, while reset is held
  task automatic t_reset();
    chk({req_ready, drn_ready, rd_linefill, fetch_req, drn_done, wr_cache}, 6'h30, "reset");
  endtask
  // Every attribute class read, then writes, all back to back
  task automatic t_lookups();
    look(1'b0, 4'h2, 1'b1, 4'b0100);
    look(1'b0, 4'h3, 1'b0, 4'b0100);
    look(1'b0, 4'h6, 1'b1, 4'b1000);
    look(1'b0, 4'hf, 1'b1, 4'b1000);
    look(1'b0, 4'h6, 1'b0, 4'b0010);
    look(1'b0, 4'h7, 1'b0, 4'b0010);
    look(1'b0, 4'ha, 1'b0, 4'b0100);
    look(1'b0, 4'hb, 1'b0, 4'b0100);
    look(1'b1, 4'h2, 1'b0, 4'b0001);
    look(1'b1, 4'hf, 1'b1, 4'b0001);
    req_valid = 1'b0;
  endtask
  task automatic t_drain_hits();
    drain(4'h3, 1'b0, 1'b1, 5'b01000);
    drain(4'h6, 1'b1, 1'b1, 5'b11000);
    drain(4'h7, 1'b1, 1'b1, 5'b10010);
  endtask
  task automatic t_drain_misses();
    drain(4'h7, 1'b0, 1'b1, 5'b01000);
    drain(4'ha, 1'b0, 1'b1, 5'b11100);
    drain(4'hb, 1'b0, 1'b1, 5'b10110);
  endtask
  // Partial entries: prompt memory, then a slow one
  task automatic t_partial();
    drain(4'he, 1'b0, 1'b0, 5'b11101);
    dly = 4'h9;
    drain(4'hf, 1'b0, 1'b0, 5'b10111);
  endtask
  initial begin
    repeat (20) @(negedge clk);
    t_reset();
    resetn = 1'b1;
    @(negedge clk);
    t_lookups();
    t_drain_hits();
    t_drain_misses();
    t_partial();
    close_out();
  end
endmodule // cap_policy_test
`default_nettype wire
